// >>> include/swtc_regs.svh
`ifndef SWTC_REGS_SVH
`define SWTC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SWTC_CTRL_OFS 8'h00
`define SWTC_TIME_OFS 8'h04
`define SWTC_TRIG_OFS 8'h08
`define SWTC_STAT_OFS 8'h0c
`define SWTC_POS_OFS 8'h10

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SWTC_EN_BIT 0
`define SWTC_SRC_LSB 1
`define SWTC_EXT_NEG_BIT 3
`define SWTC_OUT_EN_BIT 4
`define SWTC_OUT_NEG_BIT 5
`define SWTC_RRST_BIT 6
`define SWTC_CMD_BIT 0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SWTC_CTRL_RST 7'h00
`define SWTC_TIME_RST 32'h000f4240
`define SWTC_CLK_NS 10
`define SWTC_TICK_NS 1000
`define SWTC_TICK_CYC ((`SWTC_TICK_NS + `SWTC_CLK_NS - 1) / `SWTC_CLK_NS)
`define SWTC_PULSE_US 32'h00000001

`endif

// >>> include/swtc_pkg.sv
`default_nettype none
package swtc_pkg;
	// Trigger source encoding
	typedef enum logic [1:0] {
		SWTC_SRC_INT = 2'h0,
		SWTC_SRC_EXT = 2'h1,
		SWTC_SRC_MAN = 2'h2
	} swtc_src_e;
	// Sweep sequencer states
	typedef enum logic {SWTC_IDLE, SWTC_RUN} swtc_state_e;
endpackage
`default_nettype wire

// >>> rtl/swtc_top.sv
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "swtc_regs.svh"
module swtc_top #(
	parameter int TW = 32
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Trigger pins
	input wire logic i_trig_in,
	output logic o_trig_out,
	// Sweep engine side
	output logic o_sweep_active,
	output logic o_sweep_start,
	output logic o_wait_manual,
	output logic [TW-1:0] o_sweep_pos
);
	import swtc_pkg::*;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	generate
		if (TW < 20 || TW > 32) begin : g_bad_tw
			$error("swtc_top: TW must be 20 to 32");
		end
	endgenerate

	localparam logic [7:0] TICK_LAST = 8'(`SWTC_TICK_CYC - 1);
	localparam logic [6:0] CTRL_RST = `SWTC_CTRL_RST;
	localparam logic [31:0] TIME_RST = `SWTC_TIME_RST;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic ack_r;
	logic [31:0] rdat_r;
	logic wr_req;
	logic wr_ctrl;
	logic wr_time;
	logic wr_cmd;
	logic rrst;
	logic [31:0] rd_mux;

	// A request is taken once, in the cycle before ack
	assign wr_req = i_wb_cyc & i_wb_stb & i_wb_we & ~ack_r;
	assign wr_ctrl = wr_req & (i_wb_adr == `SWTC_CTRL_OFS) & i_wb_sel[0];
	assign wr_time = wr_req & (i_wb_adr == `SWTC_TIME_OFS);
	assign wr_cmd = wr_req & (i_wb_adr == `SWTC_TRIG_OFS) & i_wb_sel[0]
		& i_wb_dat[`SWTC_CMD_BIT];
	assign rrst = wr_ctrl & i_wb_dat[`SWTC_RRST_BIT];

	// ----------------------------------------
	// Settings
	// ----------------------------------------
	logic en_r;
	swtc_src_e src_r;
	logic ext_neg_r;
	logic out_en_r;
	logic out_neg_r;
	logic [31:0] time_r;

	// Control register; a remote reset restores all defaults
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n || rrst) begin
			ext_neg_r <= CTRL_RST[`SWTC_EXT_NEG_BIT];
			out_en_r <= CTRL_RST[`SWTC_OUT_EN_BIT];
			out_neg_r <= CTRL_RST[`SWTC_OUT_NEG_BIT];
			en_r <= CTRL_RST[`SWTC_EN_BIT];
			src_r <= SWTC_SRC_INT;
		end else if (wr_ctrl) begin
			en_r <= i_wb_dat[`SWTC_EN_BIT];
			ext_neg_r <= i_wb_dat[`SWTC_EXT_NEG_BIT];
			out_en_r <= i_wb_dat[`SWTC_OUT_EN_BIT];
			out_neg_r <= i_wb_dat[`SWTC_OUT_NEG_BIT];
			// Code 3 is not a source and leaves the choice as it was
			if (i_wb_dat[`SWTC_SRC_LSB+:2] != 2'h3) begin
				src_r <= swtc_src_e'(i_wb_dat[`SWTC_SRC_LSB+:2]);
			end
		end
	end

	// Sweep time in microseconds, written per byte lane
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_time_lane
			logic [7:0] lane_r;
			always_ff @(posedge i_sys_clk) begin
				if (!i_reset_n || rrst) begin
					lane_r <= TIME_RST[8*b+:8];
				end else if (wr_time && i_wb_sel[b]) begin
					lane_r <= i_wb_dat[8*b+:8];
				end
			end
			assign time_r[8*b+:8] = lane_r;
		end
	endgenerate

	// ----------------------------------------
	// Trigger input synchroniser
	// ----------------------------------------
	logic trig_meta_r;
	logic trig_sync_r;
	logic trig_prev_r;
	logic ext_edge;

	// Two stages before any logic looks at the pin
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			trig_meta_r <= 1'b0;
			trig_sync_r <= 1'b0;
			trig_prev_r <= 1'b0;
		end else begin
			trig_meta_r <= i_trig_in;
			trig_sync_r <= trig_meta_r;
			trig_prev_r <= trig_sync_r;
		end
	end

	// Qualifying edge by slope
	assign ext_edge = ext_neg_r ? (trig_prev_r & ~trig_sync_r)
		: (trig_sync_r & ~trig_prev_r);

	// ----------------------------------------
	// Microsecond tick
	// ----------------------------------------
	logic [7:0] tick_cnt_r;
	logic tick_r;
	logic start_go;

	// Divider restarted at each sweep start, so every sweep lasts whole ticks
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			tick_cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end else if (start_go) begin
			tick_cnt_r <= 8'h01;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == TICK_LAST);
			tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? 8'h00 : tick_cnt_r + 8'h01;
		end
	end

	// ----------------------------------------
	// Sweep sequencer
	// ----------------------------------------
	swtc_state_e state_r;
	swtc_state_e state_nxt;
	logic [TW-1:0] elapsed_r;
	logic [TW-1:0] elapsed_nxt;
	logic [TW-1:0] last_us;
	logic end_now;

	assign last_us = TW'(time_r - 32'h1);
	assign end_now = (state_r == SWTC_RUN) & tick_r & (elapsed_r >= last_us);

	// Start decision per source
	always_comb begin
		start_go = 1'b0;
		if (en_r) begin
			unique case (src_r)
				SWTC_SRC_INT: start_go = (state_r == SWTC_IDLE) | end_now;
				SWTC_SRC_EXT: start_go = (state_r == SWTC_IDLE) & ext_edge;
				SWTC_SRC_MAN: start_go = (state_r == SWTC_IDLE) & wr_cmd;
				default: start_go = 1'b0;
			endcase
		end
	end

	// Next state and position; busy edges fall through unused
	always_comb begin
		state_nxt = state_r;
		elapsed_nxt = elapsed_r;
		if (!en_r) begin
			state_nxt = SWTC_IDLE;
			elapsed_nxt = '0;
		end else if (start_go) begin
			state_nxt = SWTC_RUN;
			elapsed_nxt = '0;
		end else if (end_now) begin
			state_nxt = SWTC_IDLE;
			elapsed_nxt = '0;
		end else if (state_r == SWTC_RUN && tick_r) begin
			elapsed_nxt = elapsed_r + TW'(1);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			state_r <= SWTC_IDLE;
			elapsed_r <= '0;
		end else begin
			state_r <= state_nxt;
			elapsed_r <= elapsed_nxt;
		end
	end

	// Engine side outputs
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_sweep_active <= 1'b0;
			o_sweep_start <= 1'b0;
			o_wait_manual <= 1'b0;
			o_sweep_pos <= '0;
		end else begin
			o_sweep_active <= (state_nxt == SWTC_RUN);
			o_sweep_start <= start_go;
			o_sweep_pos <= elapsed_nxt;
			o_wait_manual <= en_r & (src_r == SWTC_SRC_MAN)
				& (state_nxt == SWTC_IDLE);
		end
	end

	// ----------------------------------------
	// Trigger output
	// ----------------------------------------
	logic [TW-1:0] act_lim;
	logic out_act;

	// Internal: first half of the sweep; others: a short pulse
	assign act_lim = (src_r == SWTC_SRC_INT) ? TW'(time_r >> 1)
		: TW'(`SWTC_PULSE_US);
	assign out_act = (state_nxt == SWTC_RUN) & (elapsed_nxt < act_lim);

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_trig_out <= 1'b0;
		end else begin
			o_trig_out <= (out_en_r & en_r & out_act) ^ out_neg_r;
		end
	end

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (i_wb_adr)
			`SWTC_CTRL_OFS: rd_mux = {26'h0, out_neg_r, out_en_r, ext_neg_r, src_r, en_r};
			`SWTC_TIME_OFS: rd_mux = time_r;
			`SWTC_STAT_OFS: rd_mux = {29'h0, o_trig_out, o_wait_manual, o_sweep_active};
			`SWTC_POS_OFS: rd_mux = 32'(elapsed_r);
			default: rd_mux = 32'h00000000;
		endcase
	end

	// One wait state; ack drops the cycle after
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h00000000;
		end else begin
			ack_r <= i_wb_cyc & i_wb_stb & ~ack_r;
			rdat_r <= rd_mux;
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rdat_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_src_back_int: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		rrst |=> (src_r == SWTC_SRC_INT) && !en_r)
		else $error("source not internal after remote reset");

	a_int_back_back: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		end_now && en_r && src_r == SWTC_SRC_INT |=> o_sweep_start && o_sweep_active)
		else $error("internal sweep not restarted at once");

	a_ext_edge_start: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		en_r && src_r == SWTC_SRC_EXT && state_r == SWTC_IDLE && ext_edge
		|=> o_sweep_start ##1 !o_sweep_start)
		else $error("external edge gave no single start");

	a_slope_pick: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		ext_edge == (ext_neg_r ? $fell(trig_sync_r) : $rose(trig_sync_r)))
		else $error("edge taken against the slope setting");

	a_busy_ignore: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		state_r == SWTC_RUN && !end_now |=> !o_sweep_start)
		else $error("start during running sweep");

	a_man_cmd_start: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_wait_manual && wr_cmd && en_r |=> o_sweep_start ##1 !o_wait_manual)
		else $error("manual command gave no sweep");

	a_wait_clears: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_sweep_active |-> !o_wait_manual)
		else $error("waiting flag during sweep");

	a_off_no_sweep: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!en_r |=> !o_sweep_active && (o_trig_out == $past(out_neg_r)))
		else $error("sweep or trigger out while disabled");

	a_out_edge_start: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		start_go && out_en_r |=> o_trig_out == !$past(out_neg_r))
		else $error("no active trigger edge at start");

	a_square_half: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_sweep_active && out_en_r && !out_neg_r && src_r == SWTC_SRC_INT
		&& o_sweep_pos >= TW'(time_r >> 1) |-> !o_trig_out)
		else $error("square not low in second half");

	a_pos_bound: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!o_sweep_active |-> o_sweep_pos == '0)
		else $error("position not at start while idle");

	// Cycles since the last sweep start, for the length check
	logic [39:0] run_cyc_r;

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n || start_go) begin
			run_cyc_r <= 40'h0;
		end else begin
			run_cyc_r <= run_cyc_r + 40'h1;
		end
	end

	a_sweep_length: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		end_now |-> run_cyc_r == 40'(time_r) * 40'(`SWTC_TICK_CYC) - 40'h1)
		else $error("sweep length differs from the sweep time");

	a_ack_single: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_wb_ack |=> !o_wb_ack)
		else $error("bus acknowledge held longer than one cycle");
endmodule
`default_nettype wire

// >>> tb/swtc_ext_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Trigger source and output monitor
// ----------------------------------------
module swtc_ext_partner (
	// Clock
	input wire logic i_sys_clk,
	// Trigger pins
	input wire logic i_trig_out,
	output logic o_trig_in
);
	int rise_cnt = 0;
	logic last_r = 1'b0;

	// TTL level source, moved just after a clock edge
	initial o_trig_in = 1'b0;
	task automatic drive(input logic v);
		@(posedge i_sys_clk);
		o_trig_in <= v;
	endtask

	// Downstream equipment counting rising edges
	always @(posedge i_sys_clk) begin
		last_r <= i_trig_out;
		if (i_trig_out && !last_r) begin
			rise_cnt <= rise_cnt + 1;
		end
	end
endmodule
`default_nettype wire

// >>> tb/test_sweep_trigger_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "swtc_regs.svh"
module test_sweep_trigger_control;
	import swtc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic neg = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, wb_rd, pos;
	logic ack, trig_in, trig_out, active, start, waitm;
	int error_cnt = 0;
	int compares = 0;
	int start_cnt = 0, per_cnt = 0, last_per = 0, hi_cnt = 0, hi_last = 0, pos_max = 0, r0;

	// ----------------------------------------
	// Design, far side, clock
	// ----------------------------------------
	swtc_top uut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_trig_in(trig_in), .o_trig_out(trig_out), .o_sweep_active(active),
		.o_sweep_start(start), .o_wait_manual(waitm), .o_sweep_pos(pos));
	swtc_ext_partner ext (.i_sys_clk(clk), .i_trig_out(trig_out), .o_trig_in(trig_in));
	initial forever #5 clk = ~clk;

	// Sweep period, active output time and peak position
	always @(posedge clk) begin
		if (start) begin
			start_cnt <= start_cnt + 1;
			last_per <= per_cnt;
			per_cnt <= 1;
			hi_last <= hi_cnt;
			hi_cnt <= int'(trig_out ^ neg);
			pos_max <= 0;
		end else begin
			per_cnt <= per_cnt + 1;
			hi_cnt <= hi_cnt + int'(trig_out ^ neg);
			if (int'(pos) > pos_max) pos_max <= int'(pos);
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic single cycle; ack and read data taken at the same rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		wb_rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wait_for(input logic v, input int lim, input bit on_start);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((on_start ? start : active) !== v && n < lim);
		if ((on_start ? start : active) !== v) error_cnt++;
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] s, input logic xn, input logic on);
		ctl = 32'h0;
		ctl[`SWTC_EN_BIT] = on;
		ctl[`SWTC_SRC_LSB +: 2] = s;
		ctl[`SWTC_EXT_NEG_BIT] = xn;
		ctl[`SWTC_OUT_EN_BIT] = 1'b1;
		ctl[`SWTC_OUT_NEG_BIT] = xn;
	endfunction

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Watchdog well past the expected run
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		tally_and_finish;
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, `SWTC_CTRL_OFS, 32'h0);
		chk(wb_rd, 32'h0);
		wb(1'b0, `SWTC_TIME_OFS, 32'h0);
		chk(wb_rd, `SWTC_TIME_RST);
		wb(1'b1, 8'h20, 32'hffffffff);
		wb(1'b0, 8'h20, 32'h0);
		chk(wb_rd, 32'h0);
		// Internal source, four microsecond sweeps
		wb(1'b1, `SWTC_TIME_OFS, 32'h4);
		r0 = ext.rise_cnt;
		wb(1'b1, `SWTC_CTRL_OFS, ctl(SWTC_SRC_INT, 1'b0, 1'b1));
		repeat (3) begin
			wait_for(1'b1, 600, 1'b1);
			chk(32'(trig_out), 32'h1);
		end
		@(negedge clk);
		chk(32'(last_per), 32'h190);
		chk(32'(hi_last), 32'hc8);
		chk(32'(ext.rise_cnt - r0), 32'h3);
		// Manual source, second command lands mid-sweep
		wb(1'b1, `SWTC_CTRL_OFS, ctl(SWTC_SRC_MAN, 1'b0, 1'b1));
		wait_for(1'b0, 600, 1'b0);
		repeat (3) @(negedge clk);
		chk(32'(waitm), 32'h1);
		r0 = start_cnt;
		wb(1'b1, `SWTC_TRIG_OFS, 32'h1);
		@(negedge clk);
		chk(32'(start_cnt - r0), 32'h1);
		wb(1'b1, `SWTC_TRIG_OFS, 32'h1);
		@(negedge clk);
		chk(32'(waitm), 32'h0);
		wait_for(1'b0, 600, 1'b0);
		@(negedge clk);
		chk(32'(start_cnt - r0), 32'h1);
		chk(32'(hi_cnt), 32'h64);
		chk(32'(pos_max), 32'h3);
		chk(pos, 32'h0);
		chk(32'(waitm), 32'h1);
		// External source, both slopes, wrong and late edges
		for (int s = 0; s < 2; s++) begin
			neg <= s[0];
			wb(1'b1, `SWTC_CTRL_OFS, ctl(SWTC_SRC_EXT, s[0], 1'b0));
			r0 = start_cnt;
			ext.drive(~s[0]);
			repeat (10) @(negedge clk);
			chk(32'(trig_out), 32'(s[0]));
			wb(1'b1, `SWTC_CTRL_OFS, ctl(SWTC_SRC_EXT, s[0], 1'b1));
			ext.drive(s[0]);
			repeat (10) @(negedge clk);
			chk(32'(start_cnt - r0), 32'h0);
			ext.drive(~s[0]);
			wait_for(1'b1, 20, 1'b1);
			chk(32'(trig_out), 32'(!s[0]));
			ext.drive(s[0]);
			ext.drive(~s[0]);
			wait_for(1'b0, 600, 1'b0);
			@(negedge clk);
			chk(32'(start_cnt - r0), 32'h1);
		end
		// Remote reset returns every setting to default
		wb(1'b1, `SWTC_CTRL_OFS, 32'h1 << `SWTC_RRST_BIT);
		wb(1'b0, `SWTC_CTRL_OFS, 32'h0);
		chk(wb_rd, 32'h0);
		wb(1'b0, `SWTC_TIME_OFS, 32'h0);
		chk(wb_rd, `SWTC_TIME_RST);
		// Source code 3 is refused and keeps the external choice
		wb(1'b1, `SWTC_CTRL_OFS, 32'h2);
		wb(1'b1, `SWTC_CTRL_OFS, 32'h6);
		wb(1'b0, `SWTC_CTRL_OFS, 32'h0);
		chk(wb_rd, 32'h2);
		tally_and_finish;
	end
endmodule
`default_nettype wire
